/* File: sim/line_model.sv */
`timescale 1ns/1ps
module line_model
(
    input wire logic               sys_clk,    // Clock
    input wire logic               rst,        // Reset
    input wire logic               ring_drive, // Driver on
    input wire logic signed [15:0] ring_wave,  // Sample
    output int                     bursts,     // Ring bursts seen
    output logic                   wave_seen   // Nonzero sample seen
);
    logic drive_q;
    // Counts bursts and flags nonzero samples; the line itself presents no load effects
    always_ff @(posedge sys_clk)
    begin
        drive_q <= ring_drive;
        if (rst)
        begin
            bursts    <= 0;
            wave_seen <= 1'b0;
        end
        else
        begin
            if (ring_drive === 1'b1 && drive_q === 1'b0)
                bursts <= bursts + 1;
            if (ring_drive === 1'b1 && ring_wave !== 16'sh0000)
                wave_seen <= 1'b1;
        end
    end
endmodule : line_model

/* File: sim/ring_checker.sv */
`timescale 1ns/1ps
module ring_checker
    import ring_gen_pkg::*;
#(
    parameter int unsigned TICK_CLKS = 4 // Tick length
)
(
    input wire logic                   sys_clk,                 // Clock
    input wire logic                   rst,                     // Reset
    input wire logic [7:0]             reg_addr,                // Address
    input wire logic                   reg_wr,                  // Write
    input wire logic                   reg_rd,                  // Read
    input wire logic [7:0]             reg_rdata,               // Read data
    input wire logic                   reg_rvalid,              // Read valid
    input wire logic signed [15:0]     ring_wave,               // Sample
    input wire logic                   ring_drive,              // Driving
    input wire logic [2:0]             line_state,              // Line state
    input wire logic [CM_MARGIN_W-1:0] ring_common_mode_margin  // Margin
);
    // ====================================
    // Properties
    // ====================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_valid_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("stray read valid");
    a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved");
    a_quiet_when_off: assert property (!ring_drive && !$past(ring_drive) |-> ring_wave == 0)
        else $error("wave while not driving");
    a_drive_in_ring: assert property (ring_drive && $past(ring_drive) |-> line_state == 3'h4)
        else $error("drive outside ringing");
    a_onhook_silent: assert property (line_state == 3'h2 && $past(line_state) == 3'h2
        |-> !ring_drive)
        else $error("drive during on-hook");
    a_expiry_onhook: assert property ($past(line_state) == 3'h4 && line_state != 3'h4
        && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3) |-> line_state == 3'h2)
        else $error("ring end not on-hook");
    // Store lands on the edge that samples the command; the check also accepts one edge later
    a_margin_by_cmd: assert property (!$stable(ring_common_mode_margin)
        |-> ($past(reg_wr) && $past(reg_addr) == 8'h1F)
        || ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h1F))
        else $error("margin moved unasked");
    c_ring_start: cover property ($rose(ring_drive));
    c_ring_stop: cover property ($fell(ring_drive));
    c_read: cover property (reg_rvalid);
endmodule : ring_checker

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import ring_gen_pkg::*;
    logic               sys_clk = 0;
    logic               rst = 1;
    logic               reg_wr = 0;
    logic               reg_rd = 0;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic [7:0]         reg_rdata;
    logic               reg_rvalid;
    logic signed [15:0] ring_wave;
    logic               ring_drive;
    logic [2:0]         line_state;
    logic [3:0]         margin;
    logic [5:0]         supply;
    logic               wave_seen;
    int                 bursts;
    int                 mismatches = 0;
    int                 checks_done = 0;
    int                 n;
    logic [23:0]        rows [7] = '{24'h22FF1F, 24'h30A5A5, 24'h315A5A, 24'h323C3C,
                                     24'h33C3C3, 24'h4A3F3F, 24'h057700};
    always #10 sys_clk = ~sys_clk;
    ring_generator #(.TICK_CLKS(4)) u_ring_generator (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ring_wave(ring_wave),
        .ring_drive(ring_drive), .line_state(line_state),
        .ring_common_mode_margin(margin), .high_supply_level(supply));
    line_model u_line_model (.sys_clk(sys_clk), .rst(rst), .ring_drive(ring_drive),
        .ring_wave(ring_wave), .bursts(bursts), .wave_seen(wave_seen));
    // ====================================
    // Tasks
    // ====================================
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t byte %h want %h", $time, got, exp);
        end
    endtask : chk8
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        chk8(got[15:8], exp[15:8]);
        chk8(got[7:0], exp[7:0]);
    endtask : chk16
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk8({7'h00, reg_rvalid}, 8'h01);
        chk8(reg_rdata, exp);
    endtask : rd
    task wind(input logic [7:0] ia, input logic [15:0] v);
        wr(8'h1C, v[7:0]);
        wr(8'h1D, v[15:8]);
        wr(8'h1F, ia);
    endtask : wind
    task rind(input logic [7:0] ia, input logic [15:0] exp);
        wr(8'h1E, ia);
        rd(8'h1C, exp[7:0]);
        rd(8'h1D, exp[15:8]);
    endtask : rind
    // Waits for the level, then counts how long it lasts
    task span(input logic lvl, output int len);
        len = 0;
        for (int i = 0; i < 400 && ring_drive !== lvl; i++)
            @(negedge sys_clk);
        while (ring_drive === lvl && len < 400)
        begin
            @(negedge sys_clk);
            len++;
        end
        if (len == 0 || len >= 400)
        begin
            mismatches++;
            $display("MISMATCH %0t drive level stuck", $time);
            results();
        end
    endtask : span
    // ====================================
    // Sequence
    // ====================================
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h22, 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk8({2'b00, supply}, 8'h3F);
        wind(IND_CM_MARGIN, 16'h0009);
        // Store lands on the edge that ends the write
        @(negedge sys_clk);
        chk8({4'h0, margin}, 8'h09);
        wr(8'h30, 8'h10);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'h02);
        wr(8'h33, 8'h00);
        wind(IND_FREQ, 16'h7EFD);
        wind(IND_AMP, 16'h0177);
        wind(IND_PHASE, 16'h0000);
        wr(8'h22, 8'h1C);
        wr(8'h40, 8'h04);
        span(1'b1, n);
        chk8({5'h00, line_state}, 8'h02);
        span(1'b0, n);
        chk8(n[7:0], 8'h08);
        chk8({5'h00, line_state}, 8'h04);
        span(1'b1, n);
        chk8(n[7:0], 8'h40);
        chk8({7'h00, bursts >= 2}, 8'h01);
        chk8({7'h00, wave_seen}, 8'h01);
        wr(8'h40, 8'h01);
        repeat (3) @(negedge sys_clk);
        chk8({7'h00, ring_drive}, 8'h00);
        rd(8'h40, 8'h11);
        wind(IND_FREQ, 16'h0010);
        wind(IND_AMP, 16'h0030);
        wind(IND_PHASE, 16'h0100);
        wind(IND_DC_OFFSET, 16'h0100);
        wr(8'h22, 8'h07);
        wr(8'h40, 8'h04);
        repeat (60) @(negedge sys_clk);
        chk16(ring_wave, 16'h0130);
        wr(8'h22, 8'h05);
        repeat (4) @(negedge sys_clk);
        chk16(ring_wave, 16'h0030);
        rind(IND_DC_OFFSET, 16'h0100);
        rind(8'h50, 16'h0000);
        // Mid-run reset while ringing; held three edges so $past sees reset values
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk16(ring_wave, 16'h0000);
        chk8({4'h0, ring_drive, line_state}, 8'h00);
        rd(8'h40, 8'h00);
        results();
    end
endmodule : testbench
bind ring_generator ring_checker #(.TICK_CLKS(TICK_CLKS)) u_ring_checker (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ring_wave(ring_wave),
    .ring_drive(ring_drive), .line_state(line_state),
    .ring_common_mode_margin(ring_common_mode_margin));

/* File: verilog/ring_gen_pkg.sv */
package ring_gen_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned SYS_CLK_HZ       = 50_000_000;
    localparam int unsigned CLK_PER_US       = SYS_CLK_HZ / 1_000_000;
    localparam int unsigned TICK_TIME_US     = 125;
    localparam int unsigned TICK_CYCLES      = CLK_PER_US * TICK_TIME_US;
    localparam int unsigned UPDATE_TIME_US   = 1000;
    localparam int unsigned TICKS_PER_UPDATE = UPDATE_TIME_US / TICK_TIME_US;

    // ==========================================================
    // Direct register map
    // ==========================================================
    localparam logic [7:0] ADDR_IND_DATA_LO  = 8'h1C;
    localparam logic [7:0] ADDR_IND_DATA_HI  = 8'h1D;
    localparam logic [7:0] ADDR_IND_RD       = 8'h1E;
    localparam logic [7:0] ADDR_IND_WR       = 8'h1F;
    localparam logic [7:0] ADDR_RING_CTRL    = 8'h22;
    localparam logic [7:0] ADDR_ON_LO        = 8'h30;
    localparam logic [7:0] ADDR_ON_HI        = 8'h31;
    localparam logic [7:0] ADDR_OFF_LO       = 8'h32;
    localparam logic [7:0] ADDR_OFF_HI       = 8'h33;
    localparam logic [7:0] ADDR_LINE_FEED    = 8'h40;
    localparam logic [7:0] ADDR_HIGH_SUPPLY  = 8'h4A;

    // ==========================================================
    // Indirect register map
    // ==========================================================
    localparam logic [7:0] IND_DC_OFFSET     = 8'h13;
    localparam logic [7:0] IND_FREQ          = 8'h14;
    localparam logic [7:0] IND_AMP           = 8'h15;
    localparam logic [7:0] IND_PHASE         = 8'h16;
    localparam logic [7:0] IND_CM_MARGIN     = 8'h28;

    // ==========================================================
    // Fields
    // ==========================================================
    localparam int unsigned CTRL_SHAPE_BIT   = 0;
    localparam int unsigned CTRL_OFFSET_BIT  = 1;
    localparam int unsigned CTRL_OSC_BIT     = 2;
    localparam int unsigned CTRL_OFF_TMR_BIT = 3;
    localparam int unsigned CTRL_ON_TMR_BIT  = 4;
    localparam logic [7:0]  CTRL_MASK        = 8'h1F;
    localparam int unsigned LF_SHADOW_LSB    = 4;
    localparam int unsigned CM_MARGIN_W      = 4;
    localparam int unsigned SUPPLY_W         = 6;
    localparam logic [2:0]  LF_RINGING       = 3'h4;
    localparam logic [2:0]  LF_ONHOOK_TX     = 3'h2;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic [15:0] RESET_WORD       = 16'h0000;

    typedef enum logic [3:0]
    {
        CAD_IDLE = 4'h1,
        CAD_ON   = 4'h2,
        CAD_OFF  = 4'h4,
        CAD_HOLD = 4'h8
    } cadence_type;

endpackage : ring_gen_pkg

/* File: verilog/ring_generator.sv */
`timescale 1ns/1ps
module ring_generator
    import ring_gen_pkg::*;
#(
    parameter int unsigned TICK_CLKS = TICK_CYCLES // 125 us in clocks
)
(
    input  wire logic                   sys_clk,                 // 50 MHz clock
    input  wire logic                   rst,                     // Sync reset, high
    input  wire logic [7:0]             reg_addr,                // Direct register number
    input  wire logic                   reg_wr,                  // Write strobe
    input  wire logic [7:0]             reg_wdata,               // Write data
    input  wire logic                   reg_rd,                  // Read strobe
    output logic      [7:0]             reg_rdata,               // Read data
    output logic                        reg_rvalid,              // Read data valid
    output logic signed [15:0]          ring_wave,               // Ringing sample
    output logic                        ring_drive,              // Waveform driven
    output logic      [2:0]             line_state,              // Actual line state
    output logic      [CM_MARGIN_W-1:0] ring_common_mode_margin, // 1.5 V per step
    output logic      [SUPPLY_W-1:0]    high_supply_level        // High supply setting
);

    ring_osc_if osc_bus ();

    // ==========================================================
    // Register storage
    // ==========================================================
    logic        [7:0]             ctrl_q;
    logic        [15:0]            ring_on_period_q;
    logic        [15:0]            ring_off_period_q;
    logic        [2:0]             line_feed_state_q;
    logic        [SUPPLY_W-1:0]    supply_q;
    logic        [15:0]            ind_data_q;
    logic signed [15:0]            ring_dc_offset_q;
    logic signed [15:0]            ring_freq_coeff_q;
    logic signed [15:0]            ring_amp_coeff_q;
    logic signed [15:0]            ring_phase_coeff_q;
    logic        [CM_MARGIN_W-1:0] cm_margin_q;
    logic        [7:0]             rdata_d;
    logic        [15:0]            ind_rd_d;
    logic                          wr_ind;

    logic ring_shape_select;
    logic ring_offset_enable;
    logic ring_osc_enable;
    logic ring_off_timer_enable;
    logic ring_on_timer_enable;

    assign ring_shape_select     = ctrl_q[CTRL_SHAPE_BIT];
    assign ring_offset_enable    = ctrl_q[CTRL_OFFSET_BIT];
    assign ring_osc_enable       = ctrl_q[CTRL_OSC_BIT];
    assign ring_off_timer_enable = ctrl_q[CTRL_OFF_TMR_BIT];
    assign ring_on_timer_enable  = ctrl_q[CTRL_ON_TMR_BIT];

    // ==========================================================
    // Tick generation
    // ==========================================================
    // One base tick of 125 us serves cadence and trapezoid steps
    logic [$clog2(TICK_CLKS)-1:0]        tick_cnt_q;
    logic [$clog2(TICKS_PER_UPDATE)-1:0] upd_cnt_q;
    logic                                tick;
    logic                                tick_update;

    assign tick        = (tick_cnt_q == ($clog2(TICK_CLKS))'(TICK_CLKS - 1));
    assign tick_update = tick && (upd_cnt_q == ($clog2(TICKS_PER_UPDATE))'(TICKS_PER_UPDATE - 1));

    always_ff @(posedge sys_clk)
    begin
        if (rst || tick)
        begin
            tick_cnt_q <= '0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            upd_cnt_q <= '0;
        end
        else if (tick)
        begin
            upd_cnt_q <= upd_cnt_q + 1'b1;
        end
    end

    // ==========================================================
    // Direct register writes
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q            <= RESET_BYTE;
            ring_on_period_q  <= RESET_WORD;
            ring_off_period_q <= RESET_WORD;
            line_feed_state_q <= '0;
            supply_q          <= '0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                ADDR_RING_CTRL:   ctrl_q                  <= reg_wdata & CTRL_MASK;
                ADDR_ON_LO:       ring_on_period_q[7:0]   <= reg_wdata;
                ADDR_ON_HI:       ring_on_period_q[15:8]  <= reg_wdata;
                ADDR_OFF_LO:      ring_off_period_q[7:0]  <= reg_wdata;
                ADDR_OFF_HI:      ring_off_period_q[15:8] <= reg_wdata;
                ADDR_LINE_FEED:   line_feed_state_q       <= reg_wdata[2:0];
                ADDR_HIGH_SUPPLY: supply_q                <= reg_wdata[SUPPLY_W-1:0];
                default:          ;
            endcase
        end
    end

    // ==========================================================
    // Indirect access window
    // ==========================================================
    // Accesses finish in one cycle, so no busy flag is needed
    assign wr_ind = reg_wr && (reg_addr == ADDR_IND_WR);

    always_comb
    begin
        case (reg_wdata)
            IND_DC_OFFSET: ind_rd_d = ring_dc_offset_q;
            IND_FREQ:      ind_rd_d = ring_freq_coeff_q;
            IND_AMP:       ind_rd_d = ring_amp_coeff_q;
            IND_PHASE:     ind_rd_d = ring_phase_coeff_q;
            IND_CM_MARGIN: ind_rd_d = {{(16-CM_MARGIN_W){1'b0}}, cm_margin_q};
            default:       ind_rd_d = RESET_WORD;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ind_data_q <= RESET_WORD;
        end
        else if (reg_wr && reg_addr == ADDR_IND_DATA_LO)
        begin
            ind_data_q[7:0] <= reg_wdata;
        end
        else if (reg_wr && reg_addr == ADDR_IND_DATA_HI)
        begin
            ind_data_q[15:8] <= reg_wdata;
        end
        else if (reg_wr && reg_addr == ADDR_IND_RD)
        begin
            ind_data_q <= ind_rd_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ring_dc_offset_q   <= RESET_WORD;
            ring_freq_coeff_q  <= RESET_WORD;
            ring_amp_coeff_q   <= RESET_WORD;
            ring_phase_coeff_q <= RESET_WORD;
            cm_margin_q        <= '0;
        end
        else if (wr_ind)
        begin
            case (reg_wdata)
                IND_DC_OFFSET: ring_dc_offset_q   <= ind_data_q;
                IND_FREQ:      ring_freq_coeff_q  <= ind_data_q;
                IND_AMP:       ring_amp_coeff_q   <= ind_data_q;
                IND_PHASE:     ring_phase_coeff_q <= ind_data_q;
                IND_CM_MARGIN: cm_margin_q        <= ind_data_q[CM_MARGIN_W-1:0];
                default:       ;
            endcase
        end
    end

    // ==========================================================
    // Cadence state machine
    // ==========================================================
    cadence_type state_q;
    cadence_type state_d;
    logic [15:0] cad_cnt_q;
    logic        ringing_sel;
    logic        on_expired;
    logic        off_expired;

    assign ringing_sel = (line_feed_state_q == LF_RINGING);
    // Zero and one both expire on the first tick
    assign on_expired  = tick && ring_on_timer_enable
                         && ({1'b0, cad_cnt_q} + 17'h00001 >= {1'b0, ring_on_period_q});
    assign off_expired = tick && ({1'b0, cad_cnt_q} + 17'h00001 >= {1'b0, ring_off_period_q});

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CAD_IDLE:
            begin
                if (ringing_sel)
                begin
                    state_d = CAD_ON;
                end
            end
            CAD_ON:
            begin
                if (!ringing_sel)
                begin
                    state_d = CAD_IDLE;
                end
                else if (on_expired)
                begin
                    // Without the off timer the ring is a one-shot
                    state_d = ring_off_timer_enable ? CAD_OFF : CAD_HOLD;
                end
            end
            CAD_OFF:
            begin
                if (!ringing_sel)
                begin
                    state_d = CAD_IDLE;
                end
                else if (!ring_off_timer_enable)
                begin
                    state_d = CAD_HOLD;
                end
                else if (off_expired)
                begin
                    state_d = CAD_ON;
                end
            end
            CAD_HOLD:
            begin
                if (!ringing_sel)
                begin
                    state_d = CAD_IDLE;
                end
            end
            default:
            begin
                state_d = CAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        state_q <= rst ? CAD_IDLE : state_d;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || state_d != state_q || state_q == CAD_IDLE || state_q == CAD_HOLD)
        begin
            cad_cnt_q <= RESET_WORD;
        end
        else if (tick)
        begin
            cad_cnt_q <= cad_cnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // Oscillator and output
    // ==========================================================
    assign osc_bus.tick_fast   = tick;
    assign osc_bus.tick_update = tick_update;
    assign osc_bus.run         = (state_q == CAD_ON) && ring_osc_enable;
    assign osc_bus.shape_trap  = ring_shape_select;
    assign osc_bus.freq        = ring_freq_coeff_q;
    assign osc_bus.amp         = ring_amp_coeff_q;
    assign osc_bus.phase       = ring_phase_coeff_q;

    ring_oscillator u_osc
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .osc     (osc_bus)
    );

    logic signed [16:0] sum_d;

    always_comb
    begin
        sum_d = 17'(osc_bus.wave) + (ring_offset_enable ? 17'(ring_dc_offset_q) : 17'sd0);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || !osc_bus.run)
        begin
            ring_wave <= RESET_WORD;
        end
        else if (sum_d > 17'sd32767)
        begin
            ring_wave <= 16'sh7FFF;
        end
        else if (sum_d < -17'sd32768)
        begin
            ring_wave <= 16'sh8000;
        end
        else
        begin
            ring_wave <= sum_d[15:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ring_drive <= 1'b0;
            line_state <= '0;
        end
        else
        begin
            ring_drive <= osc_bus.run;
            case (state_q)
                CAD_ON:            line_state <= LF_RINGING;
                CAD_OFF, CAD_HOLD: line_state <= LF_ONHOOK_TX;
                default:           line_state <= line_feed_state_q;
            endcase
        end
    end

    assign ring_common_mode_margin = cm_margin_q;
    assign high_supply_level       = supply_q;

    // ==========================================================
    // Register reads
    // ==========================================================
    always_comb
    begin
        case (reg_addr)
            ADDR_IND_DATA_LO: rdata_d = ind_data_q[7:0];
            ADDR_IND_DATA_HI: rdata_d = ind_data_q[15:8];
            ADDR_RING_CTRL:   rdata_d = ctrl_q;
            ADDR_ON_LO:       rdata_d = ring_on_period_q[7:0];
            ADDR_ON_HI:       rdata_d = ring_on_period_q[15:8];
            ADDR_OFF_LO:      rdata_d = ring_off_period_q[7:0];
            ADDR_OFF_HI:      rdata_d = ring_off_period_q[15:8];
            ADDR_LINE_FEED:   rdata_d = 8'({line_state, 1'b0, line_feed_state_q});
            ADDR_HIGH_SUPPLY: rdata_d = 8'(supply_q);
            default:          rdata_d = RESET_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata  <= RESET_BYTE;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= rdata_d;
            end
        end
    end

endmodule : ring_generator

/* File: verilog/ring_osc_if.sv */
`timescale 1ns/1ps
interface ring_osc_if;
    logic               tick_fast;
    logic               tick_update;
    logic               run;
    logic               shape_trap;
    logic signed [15:0] freq;
    logic signed [15:0] amp;
    logic signed [15:0] phase;
    logic signed [15:0] wave;

    modport ctrl (output tick_fast, tick_update, run, shape_trap, freq, amp, phase,
                  input wave);
    modport osc  (input tick_fast, tick_update, run, shape_trap, freq, amp, phase,
                  output wave);
endinterface : ring_osc_if

/* File: verilog/ring_oscillator.sv */
`timescale 1ns/1ps
module ring_oscillator
    import ring_gen_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst,     // Synchronous reset
    ring_osc_if.osc  osc      // Coefficients in, samples out
);

    logic               run_q;
    logic signed [15:0] cur_q;
    logic signed [15:0] prev_q;
    logic               dir_up_q;
    logic        [15:0] half_cnt_q;
    logic signed [31:0] prod;
    logic signed [17:0] res_d;
    logic signed [17:0] ramp_d;

    // ==========================================================
    // Resonator arithmetic, Q15 coefficient
    // ==========================================================
    always_comb
    begin
        prod   = osc.freq * cur_q;
        res_d  = 18'(prod >>> 14) - 18'(prev_q);
        ramp_d = dir_up_q ? 18'(cur_q) + 18'(osc.freq) : 18'(cur_q) - 18'(osc.freq);
        if (ramp_d > 18'(osc.amp))
        begin
            ramp_d = 18'(osc.amp);
        end
        if (ramp_d < -18'(osc.amp))
        begin
            ramp_d = -18'(osc.amp);
        end
    end

    function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
        if (v > 18'sd32767)
        begin
            return 16'sh7FFF;
        end
        if (v < -18'sd32768)
        begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    // ==========================================================
    // Sample state
    // ==========================================================
    always_ff @(posedge sys_clk)
    begin
        run_q <= rst ? 1'b0 : osc.run;
        if (rst || !osc.run)
        begin
            cur_q      <= RESET_WORD;
            prev_q     <= RESET_WORD;
            dir_up_q   <= 1'b1;
            half_cnt_q <= RESET_WORD;
        end
        else if (!run_q)
        begin
            // Sine starts at the phase value; trapezoid starts at zero ramping up
            cur_q      <= osc.shape_trap ? RESET_WORD : osc.phase;
            prev_q     <= -osc.amp;
            dir_up_q   <= 1'b1;
            half_cnt_q <= RESET_WORD;
        end
        else if (osc.shape_trap && osc.tick_fast)
        begin
            cur_q <= ramp_d[15:0];
            if (half_cnt_q + 16'h0001 >= osc.phase)
            begin
                half_cnt_q <= RESET_WORD;
                dir_up_q   <= !dir_up_q;
            end
            else
            begin
                half_cnt_q <= half_cnt_q + 16'h0001;
            end
        end
        else if (!osc.shape_trap && osc.tick_update)
        begin
            prev_q <= cur_q;
            cur_q  <= sat16(res_d);
        end
    end

    assign osc.wave = cur_q;

endmodule : ring_oscillator
